/* result_store_defines.svh */
// Constants for the converter result store and compare-hit flags
`ifndef RESULT_STORE_DEFINES_SVH
`define RESULT_STORE_DEFINES_SVH
`define ADDR_W 6
`define OFF_CONTROL 6'h20
`define OFF_HIT_LOW 6'h21
`define OFF_HIT_HIGH 6'h22
`define OFF_IRQ_STATUS 6'h23
`define OFF_IRQ_MASK 6'h24
`define CONV_ON_BIT 15
`define CM_LO_BIT 0
`define CM_ALL_WRITES 2'h3
`define HIT_HIGH_BITS 2
`define IRQ_BITS 2
`define IRQ_HIT_BIT 0
`define IRQ_RESULT_BIT 1
`define RESET_WORD 16'h0000
`endif

/* result_store_pkg.sv */
// Types shared by the result store design
package result_store_pkg;
   typedef logic [15:0] word_t;
   typedef enum logic [1:0] {PORT_IDLE, PORT_SW, PORT_CONV} port_owner_t;
endpackage

/* mem_port_if.sv */
// Interface between the register bank and its word memory
`timescale 1ns/1ps
interface mem_port_if #(parameter int AW = 5);
   logic we;
   logic [AW-1:0] waddr;
   logic [15:0] wdata;
   logic re;
   logic [AW-1:0] raddr;
   logic [15:0] rdata;
   modport ctrl (output we, output waddr, output wdata, output re, output raddr, input rdata);
   modport mem (input we, input waddr, input wdata, input re, input raddr, output rdata);
endinterface

/* result_ram.sv */
// Dual-port word memory holding results and thresholds
`timescale 1ns/1ps
module result_ram #(
   parameter int DEPTH = 18,
   parameter int AW = 5
)(
   input wire logic clk,
   mem_port_if.mem port
);
   logic [15:0] mem_r [DEPTH];
   logic [15:0] rdata_r;

   // ----------------------------------------
   // Storage, never cleared so contents survive on/off
   // ----------------------------------------
   always_ff @(posedge clk)
   begin
      if (port.we)
      begin
         mem_r[port.waddr] <= port.wdata;
      end
      if (port.re)
      begin
         rdata_r <= mem_r[port.raddr];
      end
   end
   assign port.rdata = rdata_r;
endmodule

/* result_store.sv */
// Converter result store with per-channel compare-hit flags
//
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "result_store_defines.svh"

// Function
// - Dual-port RAM, one word per channel, max 32
// - Even word count, indices up to 31
// - Every word individually addressable by processor
// - Converter on: processor writes to store ignored
// - Converter off: writes program thresholds
// - Toggling converter on never clears store
// - Mode 11: flag on write or match
// - Other modes: flag only on match
// - Low hit register holds channels 15..0
// - High hit register channels 17,16; rest zero
// - Unimplemented channel flags read zero
// - Low register always, high register optional
// - Hit registers are semaphores, software acknowledges
module result_store
   import result_store_pkg::*;
#(
   parameter int CHANNELS = 18,
   parameter int WORDS = 18
)(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [`ADDR_W-1:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [15:0] rdata,
   input wire logic res_valid,
   input wire logic [4:0] res_chan,
   input wire logic [15:0] res_data,
   input wire logic match_valid,
   input wire logic [4:0] match_chan,
   output logic converter_on,
   output logic [1:0] compare_mode,
   output logic irq
);
   localparam int AW = 5;
   localparam int HW = (CHANNELS > 16) ? 32 : 16;

   // ----------------------------------------
   // Reset synchroniser
   // ----------------------------------------
   // Release passes two flops so no register leaves reset on a runt edge
   logic rst_s1_r, rst_s2_r;
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rst_s1_r <= 1'b0;
         rst_s2_r <= 1'b0;
      end
      else
      begin
         rst_s1_r <= 1'b1;
         rst_s2_r <= rst_s1_r;
      end
   end

   // Channel mask: only implemented channels hold flags
   function automatic logic [31:0] chan_bit(input logic [4:0] ch);
      logic [31:0] v;
      v = '0;
      if (int'(ch) < CHANNELS)
      begin
         v[ch] = 1'b1;
      end
      return v;
   endfunction

   // Address decode of store words, used by read and write
   function automatic logic is_word(input logic [`ADDR_W-1:0] a);
      return (int'(a) < WORDS);
   endfunction

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   word_t control_r, control_nxt;
   logic [31:0] hits_r, hits_nxt;
   logic [`IRQ_BITS-1:0] irq_stat_r, irq_stat_nxt, irq_mask_r, irq_mask_nxt;
   logic rd_word_r, rd_word_nxt;
   word_t rdata_r, rdata_nxt;
   logic [31:0] hit_set, impl_mask;
   port_owner_t owner;

   mem_port_if #(.AW(AW)) mp ();

   result_ram #(.DEPTH(WORDS), .AW(AW)) u_ram (
      .clk(clk),
      .port(mp)
   );

   assign converter_on = control_r[`CONV_ON_BIT];
   assign compare_mode = control_r[`CM_LO_BIT +: 2];
   assign impl_mask = (CHANNELS >= 32) ? '1 : ((32'h1 << CHANNELS) - 32'h1);

   // result written in its own cycle
   always_comb
   begin
      owner = PORT_IDLE;
      if (converter_on && res_valid && is_word({1'b0, res_chan}))
      begin
         owner = PORT_CONV;
      end
      else if (!converter_on && wr && is_word(addr))
      begin
         owner = PORT_SW;
      end
   end

   always_comb
   begin
      mp.we = (owner != PORT_IDLE);
      mp.waddr = (owner == PORT_CONV) ? res_chan : addr[AW-1:0];
      mp.wdata = (owner == PORT_CONV) ? res_data : wdata;
      mp.re = rd && is_word(addr);
      mp.raddr = addr[AW-1:0];
   end

   // converter result writes flag in mode 11
   always_comb
   begin
      hit_set = '0;
      if (match_valid)
      begin
         hit_set = chan_bit(match_chan);
      end
      if (owner == PORT_CONV && compare_mode == `CM_ALL_WRITES)
      begin
         hit_set = hit_set | chan_bit(res_chan);
      end
      hit_set = hit_set & impl_mask;
   end

   // ----------------------------------------
   // Next-state of control and flags
   // ----------------------------------------
   always_comb
   begin
      control_nxt = control_r;
      hits_nxt = hits_r;
      irq_mask_nxt = irq_mask_r;
      irq_stat_nxt = irq_stat_r;
      if (wr && addr == `OFF_CONTROL)
      begin
         control_nxt = wdata;
      end
      // software rewrites flags to acknowledge
      // Written value stored as is: zero acknowledges, one sets
      if (wr && addr == `OFF_HIT_LOW)
      begin
         hits_nxt[15:0] = wdata;
      end
      if (wr && addr == `OFF_HIT_HIGH && HW > 16)
      begin
         hits_nxt[17:16] = wdata[1:0];
      end
      hits_nxt = (hits_nxt | hit_set) & impl_mask;
      if (wr && addr == `OFF_IRQ_MASK)
      begin
         irq_mask_nxt = wdata[`IRQ_BITS-1:0];
      end
      if (wr && addr == `OFF_IRQ_STATUS)
      begin
         irq_stat_nxt = irq_stat_r & ~wdata[`IRQ_BITS-1:0];
      end
      // Sticky events, set beats write-one-clear
      if (|hit_set)
      begin
         irq_stat_nxt[`IRQ_HIT_BIT] = 1'b1;
      end
      if (owner == PORT_CONV)
      begin
         irq_stat_nxt[`IRQ_RESULT_BIT] = 1'b1;
      end
   end

   // high hit layout, upper bits zero
   always_comb
   begin
      rd_word_nxt = rd && is_word(addr);
      rdata_nxt = `RESET_WORD;
      if (rd)
      begin
         case (addr)
            `OFF_CONTROL: rdata_nxt = control_r;
            `OFF_HIT_LOW: rdata_nxt = hits_r[15:0];
            `OFF_HIT_HIGH: rdata_nxt = (HW > 16) ? {14'h0, hits_r[17:16]} : `RESET_WORD;
            `OFF_IRQ_STATUS: rdata_nxt = {14'h0, irq_stat_r};
            `OFF_IRQ_MASK: rdata_nxt = {14'h0, irq_mask_r};
            default: rdata_nxt = `RESET_WORD;
         endcase
      end
   end

   // ----------------------------------------
   // State registers
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_s2_r)
   begin
      if (!rst_s2_r)
      begin
         control_r <= `RESET_WORD;
         hits_r <= '0;
         irq_stat_r <= '0;
         irq_mask_r <= '0;
         rd_word_r <= 1'b0;
         rdata_r <= `RESET_WORD;
      end
      else
      begin
         control_r <= control_nxt;
         hits_r <= hits_nxt;
         irq_stat_r <= irq_stat_nxt;
         irq_mask_r <= irq_mask_nxt;
         rd_word_r <= rd_word_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // Memory words come from the RAM's own output register
   assign rdata = rd_word_r ? mp.rdata : rdata_r;
   assign irq = |(irq_stat_r & irq_mask_r);

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   // sizing checked once at simulation time zero
   initial
   begin
      size_ok_a: assert ((WORDS % 2 == 0) && WORDS <= 32 && WORDS >= CHANNELS)
         else $error("Result store size illegal");
   end

   // Store write ownership, one owner per cycle
   conv_write_a: assert property (@(posedge clk) disable iff (!rst_s2_r)
      converter_on && wr && is_word(addr) && !res_valid |-> !mp.we)
      else $error("Software wrote store while converter on");
   sw_write_a: assert property (@(posedge clk) disable iff (!rst_s2_r)
      !converter_on && wr && is_word(addr) |-> mp.we && mp.wdata == wdata)
      else $error("Threshold write lost");
   off_result_a: assert property (@(posedge clk) disable iff (!rst_s2_r)
      !converter_on && res_valid && !wr |-> !mp.we)
      else $error("Result written while converter off");
   ctrl_no_store_a: assert property (@(posedge clk) disable iff (!rst_s2_r)
      wr && addr == `OFF_CONTROL && !(converter_on && res_valid) |-> !mp.we)
      else $error("Control write touched store");
   // Flag setting per compare mode
   mode_all_a: assert property (@(posedge clk) disable iff (!rst_s2_r)
      converter_on && res_valid && compare_mode == `CM_ALL_WRITES && int'(res_chan) < CHANNELS
      |=> hits_r[$past(res_chan)])
      else $error("Mode 11 write did not flag");
   mode_match_a: assert property (@(posedge clk) disable iff (!rst_s2_r)
      compare_mode != `CM_ALL_WRITES && !match_valid && !wr |=> hits_r == $past(hits_r))
      else $error("Flag set without match");
   set_wins_a: assert property (@(posedge clk) disable iff (!rst_s2_r)
      match_valid && int'(match_chan) < CHANNELS && wr && addr == `OFF_HIT_LOW |=> hits_r[$past(match_chan)])
      else $error("Clear beat hardware set");
   // Register read layout and same-cycle result write
   high_zero_a: assert property (@(posedge clk) disable iff (!rst_s2_r)
      rd && addr == `OFF_HIT_HIGH |=> rdata[15:2] == 14'h0000)
      else $error("High hit upper bits nonzero");
   absent_zero_a: assert property (@(posedge clk) disable iff (!rst_s2_r)
      (hits_r & ~impl_mask) == 32'h0)
      else $error("Absent channel flag set");
   low_read_a: assert property (@(posedge clk) disable iff (!rst_s2_r)
      rd && addr == `OFF_HIT_LOW |=> rdata == $past(hits_r[15:0]))
      else $error("Low hit read wrong");
   read_idle_a: assert property (@(posedge clk) disable iff (!rst_s2_r)
      !rd |=> rdata == `RESET_WORD)
      else $error("Read data outside read cycle");
   same_cycle_a: assert property (@(posedge clk) disable iff (!rst_s2_r)
      converter_on && res_valid && int'(res_chan) < WORDS |-> mp.we && mp.waddr == res_chan)
      else $error("Result not written same cycle");
   // Interrupt follows sticky hit events
   irq_level_a: assert property (@(posedge clk) disable iff (!rst_s2_r)
      (|hit_set) && irq_mask_r[`IRQ_HIT_BIT] && !(wr && addr == `OFF_IRQ_MASK) |=> irq)
      else $error("Hit event did not raise interrupt");

   // ----------------------------------------
   // Cover properties
   // ----------------------------------------
   conv_cov_c: cover property (@(posedge clk) disable iff (!rst_s2_r) owner == PORT_CONV);
   sw_cov_c: cover property (@(posedge clk) disable iff (!rst_s2_r) owner == PORT_SW);
   clash_cov_c: cover property (@(posedge clk) disable iff (!rst_s2_r)
      match_valid && wr && addr == `OFF_HIT_LOW);
   irq_cov_c: cover property (@(posedge clk) disable iff (!rst_s2_r) irq);
   mode3_cov_c: cover property (@(posedge clk) disable iff (!rst_s2_r)
      owner == PORT_CONV && compare_mode == `CM_ALL_WRITES);
endmodule

/* engine_model.sv */
// Conversion engine model that delivers results and threshold matches
`timescale 1ns/1ps
module engine_model (
   input wire logic clk,
   output logic res_valid,
   output logic [4:0] res_chan,
   output logic [15:0] res_data,
   output logic match_valid,
   output logic [4:0] match_chan
);
   // ----
   // Idle levels
   // ----
   // Data bus shows a scrambled value when idle, so stale data never looks valid
   initial
   begin
      res_valid = 1'b0;
      res_chan = 5'h1f;
      res_data = 16'hdead;
      match_valid = 1'b0;
      match_chan = 5'h1f;
   end
   task automatic result(input logic [4:0] ch, input logic [15:0] d);
      @(posedge clk);
      res_valid <= 1'b1;
      res_chan <= ch;
      res_data <= d;
      @(posedge clk);
      res_valid <= 1'b0;
      res_chan <= ~ch;
      res_data <= ~d;
   endtask
   task automatic match(input logic [4:0] ch);
      @(posedge clk);
      match_valid <= 1'b1;
      match_chan <= ch;
      @(posedge clk);
      match_valid <= 1'b0;
      match_chan <= ~ch;
   endtask
endmodule

/* test_result_store.sv */
// Testbench for the result store and compare-hit flags
`timescale 1ns/1ps
`include "result_store_defines.svh"
module test_result_store
   import result_store_pkg::*;
;
   logic clk, rst_b, wr, rd, converter_on, irq;
   logic [`ADDR_W-1:0] addr;
   word_t wdata, rdata, res_data;
   logic [1:0] compare_mode;
   logic res_valid, match_valid;
   logic [4:0] res_chan, match_chan;
   int miscompares, total_checks;
   // ----
   // Clock and instances
   // ----
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   result_store #(.CHANNELS(18), .WORDS(18)) u_result_store (.clk(clk), .rst_b(rst_b), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .res_valid(res_valid), .res_chan(res_chan),
      .res_data(res_data), .match_valid(match_valid), .match_chan(match_chan),
      .converter_on(converter_on), .compare_mode(compare_mode), .irq(irq));
   engine_model u_engine_model (.clk(clk), .res_valid(res_valid), .res_chan(res_chan),
      .res_data(res_data), .match_valid(match_valid), .match_chan(match_chan));
   // ----
   // Bus and compare helpers
   // ----
   task automatic check(input word_t got, input word_t exp);
      total_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [`ADDR_W-1:0] a, input word_t d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // Read data only stands in the cycle after the strobe
   task automatic rd_reg(input logic [`ADDR_W-1:0] a, input word_t exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      check(rdata, exp);
   endtask
   task automatic irq_is(input logic exp);
      @(posedge clk);
      #1;
      check({15'h0, irq}, {15'h0, exp});
   endtask
   // ----
   // Scenarios
   // ----
   task automatic t_reset;
      rd_reg(`OFF_HIT_LOW, 16'h0000);
      rd_reg(`OFF_HIT_HIGH, 16'h0000);
      irq_is(1'b0);
      $display("test reset done");
   endtask
   task automatic t_store;
      wr_reg(6'h00, 16'h1234);
      wr_reg(6'h11, 16'habcd);
      rd_reg(6'h00, 16'h1234);
      rd_reg(6'h11, 16'habcd);
      u_engine_model.result(5'h00, 16'h0bad);
      rd_reg(6'h00, 16'h1234);
      rd_reg(6'h30, 16'h0000);
      $display("test store done");
   endtask
   task automatic t_on;
      wr_reg(`OFF_CONTROL, 16'h8003);
      #1;
      check({13'h0, compare_mode, converter_on}, 16'h0007);
      wr_reg(6'h00, 16'h5555);
      rd_reg(6'h00, 16'h1234);
      u_engine_model.result(5'h11, 16'h0777);
      rd_reg(6'h11, 16'h0777);
      rd_reg(`OFF_HIT_HIGH, 16'h0002);
      $display("test converter on done");
   endtask
   // Results alone must not flag outside the all-writes mode
   task automatic t_mode;
      for (int m = 0; m < 3; m++)
      begin
         wr_reg(`OFF_CONTROL, 16'h8000 | 16'(m));
         u_engine_model.result(5'h04, 16'h0444);
         rd_reg(`OFF_HIT_LOW, 16'h0000);
      end
      u_engine_model.match(5'h03);
      rd_reg(`OFF_HIT_LOW, 16'h0008);
      fork
         u_engine_model.match(5'h02);
         wr_reg(`OFF_HIT_LOW, 16'h0000);
      join
      rd_reg(`OFF_HIT_LOW, 16'h0004);
      wr_reg(`OFF_HIT_LOW, 16'h0000);
      rd_reg(`OFF_HIT_LOW, 16'h0000);
      u_engine_model.match(5'h14);
      rd_reg(`OFF_HIT_HIGH, 16'h0002);
      wr_reg(`OFF_HIT_HIGH, 16'hffff);
      rd_reg(`OFF_HIT_HIGH, 16'h0003);
      wr_reg(`OFF_HIT_HIGH, 16'h0000);
      wr_reg(`OFF_CONTROL, 16'h0000);
      rd_reg(6'h04, 16'h0444);
      rd_reg(6'h11, 16'h0777);
      $display("test modes done");
   endtask
   task automatic t_irq;
      wr_reg(`OFF_CONTROL, 16'h8000);
      wr_reg(`OFF_IRQ_STATUS, 16'h0003);
      wr_reg(`OFF_IRQ_MASK, 16'h0000);
      u_engine_model.match(5'h01);
      irq_is(1'b0);
      wr_reg(`OFF_IRQ_MASK, 16'h0001);
      irq_is(1'b1);
      rd_reg(`OFF_IRQ_STATUS, 16'h0001);
      wr_reg(`OFF_HIT_LOW, 16'h0000);
      wr_reg(`OFF_IRQ_STATUS, 16'h0001);
      irq_is(1'b0);
      u_engine_model.result(5'h05, 16'h0555);
      rd_reg(`OFF_IRQ_STATUS, 16'h0002);
      wr_reg(`OFF_IRQ_STATUS, 16'h0002);
      rd_reg(`OFF_IRQ_STATUS, 16'h0000);
      $display("test interrupt done");
   endtask
   // ----
   // Sequence and verdict
   // ----
   task automatic finish_test;
      $display("checks=%0d miscompares=%0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial
   begin
      miscompares = 0;
      total_checks = 0;
      rst_b = 1'b0;
      addr = '0;
      wdata = '0;
      wr = 1'b0;
      rd = 1'b0;
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      t_reset;
      t_store;
      t_on;
      t_mode;
      t_irq;
      finish_test;
   end
   // Whole run needs well under 200 cycles
   initial
   begin
      #20000;
      miscompares++;
      finish_test;
   end
endmodule
